// file: rtl/wdtu_sync.sv
// Two-flop synchroniser for a pin level
`timescale 1ns/1ns
module wdtu_sync
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic async_in,
    output logic sync_out
);
    logic stage1;

    // Resets high so a floating strap starts disabled
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stage1 <= 1'b1;
            sync_out <= 1'b1;
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : wdtu_sync

// file: rtl/wdtu_top.sv
// Watchdog timer unit: prescaler, counter, reset pulse, SFR access
// Overview of operation
// - 8-bit counter clocked by 11-bit prescaler
// - Prescaler ticks once per machine cycle
// - Counter steps every 2048 prescaler ticks
// - Counter overflow raises internal system reset
// - Overflow drives reset pin three machine cycles
// - Strap low enables the watchdog
// - No software way to disable when enabled
// - Strap high keeps watchdog disabled
// - Counter write clears the unlock flag
// - Locked counter writes are ignored
// - Up-counter: 00 longest, ff shortest interval
// - Watchdog keeps running in idle mode
// - Power-down bit held 0 while enabled
// - Counter at ff, power control at 87
`timescale 1ns/1ns
module wdtu_top
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic watchdog_enable_strap_n,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sys_reset,
    output logic reset_pin_pulse,
    output logic idle_mode,
    output logic power_down
);
    logic strap_n_sync;
    logic [3:0] mc_div;
    logic mc_tick;
    logic [wdtu_pkg::PRESCALE_BITS-1:0] prescale;
    logic [wdtu_pkg::COUNTER_BITS-1:0] watchdog_counter;
    logic [7:0] power_control;
    logic [1:0] pulse_left;
    logic enabled;
    logic wr_power_control;
    logic wr_counter;
    logic rd_power_control;
    logic rd_counter;
    logic unlocked;
    logic counter_load;
    logic prescale_full;
    logic prescale_wrap;
    logic counter_full;
    logic overflow;
    logic pulse_active;
    logic pulse_last;
    logic [7:0] next_power_control;
    logic [7:0] next_rdata;

    // Address match for the power control register
    function automatic logic is_power_control_addr
    (
        input logic [7:0] addr
    );
    begin
        return addr == wdtu_pkg::ADDR_POWER_CONTROL;
    end
    endfunction : is_power_control_addr

    // Address match for the watchdog counter
    function automatic logic is_counter_addr
    (
        input logic [7:0] addr
    );
    begin
        return addr == wdtu_pkg::ADDR_WATCHDOG_COUNTER;
    end
    endfunction : is_counter_addr

    wdtu_sync u_strap_sync
    (
        .mclk(mclk),
        .arst_n(arst_n),
        .async_in(watchdog_enable_strap_n),
        .sync_out(strap_n_sync)
    );

    // Strap low enables; no register bit can override it
    assign enabled = ~strap_n_sync;

    // Register decode
    assign wr_power_control = sfr_wr && is_power_control_addr(sfr_addr);
    assign wr_counter = sfr_wr && is_counter_addr(sfr_addr);
    assign rd_power_control = sfr_rd && is_power_control_addr(sfr_addr);
    assign rd_counter = sfr_rd && is_counter_addr(sfr_addr);

    // Reload only goes through while the unlock flag is set
    assign unlocked = power_control[wdtu_pkg::UNLOCK_BIT];
    assign counter_load = wr_counter && unlocked;

    // Ends of the prescaler and counter ranges
    assign prescale_full = &prescale;
    assign prescale_wrap = mc_tick && prescale_full;
    assign counter_full = &watchdog_counter;

    // A reload in the same cycle beats the overflow
    assign overflow = enabled && prescale_wrap && counter_full &&
        !counter_load;

    // Pin pulse ends on the machine tick that empties the count
    assign pulse_active = pulse_left != 2'h0;
    assign pulse_last = mc_tick && (pulse_left == 2'h1);

    // Machine-cycle enable, one in twelve clocks
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mc_div <= 4'h0;
            mc_tick <= 1'b0;
        end
        else if (mc_div == 4'(wdtu_pkg::MACHINE_DIV - 1))
        begin
            mc_div <= 4'h0;
            mc_tick <= 1'b1;
        end
        else
        begin
            mc_div <= mc_div + 4'h1;
            mc_tick <= 1'b0;
        end
    end

    // Prescaler; runs in idle too, cleared on reload or sys_reset, held at zero while disabled
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prescale <= '0;
        end
        else if (sys_reset || !enabled)
        begin
            prescale <= '0;
        end
        else if (counter_load)
        begin
            prescale <= '0;
        end
        else if (mc_tick)
        begin
            prescale <= prescale + 1'b1;
        end
    end

    // Up-counter, reload through unlock
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            watchdog_counter <= wdtu_pkg::COUNTER_RESET;
        end
        else if (sys_reset)
        begin
            watchdog_counter <= wdtu_pkg::COUNTER_RESET;
        end
        else if (counter_load)
        begin
            watchdog_counter <= sfr_wdata;
        end
        else if (enabled && prescale_wrap)
        begin
            watchdog_counter <= watchdog_counter + 1'b1;
        end
    end

    // Power control update with lock and power-down guard
    always_comb
    begin
        next_power_control = power_control;
        if (wr_power_control)
        begin
            next_power_control = sfr_wdata;
        end
        if (counter_load)
        begin
            next_power_control[wdtu_pkg::UNLOCK_BIT] = 1'b0;
        end
        if (enabled)
        begin
            next_power_control[wdtu_pkg::POWER_DOWN_BIT] = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            power_control <= wdtu_pkg::POWER_CONTROL_RESET;
        end
        else if (sys_reset)
        begin
            power_control <= wdtu_pkg::POWER_CONTROL_RESET;
        end
        else
        begin
            power_control <= next_power_control;
        end
    end

    // Reset pulse, three machine cycles long
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pulse_left <= 2'h0;
        end
        else if (overflow)
        begin
            pulse_left <= 2'(wdtu_pkg::PULSE_MACHINE_CYCLES);
        end
        else if (mc_tick && pulse_active)
        begin
            pulse_left <= pulse_left - 2'h1;
        end
    end

    // One-cycle internal reset
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sys_reset <= 1'b0;
        end
        else
        begin
            sys_reset <= overflow;
        end
    end

    // Pin pulse; a capacitor on the pin cannot affect sys_reset
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reset_pin_pulse <= 1'b0;
        end
        else
        begin
            reset_pin_pulse <= overflow ||
                (pulse_active && !pulse_last);
        end
    end

    // Read data select; unmapped addresses read zero
    always_comb
    begin
        next_rdata = 8'h00;
        if (rd_power_control)
        begin
            next_rdata = power_control;
        end
        else if (rd_counter)
        begin
            next_rdata = watchdog_counter;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sfr_rdata <= 8'h00;
        end
        else
        begin
            sfr_rdata <= next_rdata;
        end
    end

    // Mode outputs follow the register, cleared with it
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            idle_mode <= 1'b0;
        end
        else if (sys_reset)
        begin
            idle_mode <= 1'b0;
        end
        else
        begin
            idle_mode <= next_power_control[0];
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            power_down <= 1'b0;
        end
        else if (sys_reset)
        begin
            power_down <= 1'b0;
        end
        else
        begin
            power_down <= next_power_control[wdtu_pkg::POWER_DOWN_BIT];
        end
    end
endmodule : wdtu_top

// file: shared/wdtu_pkg.sv
// Shared constants for the watchdog timer unit
package wdtu_pkg;
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
    localparam logic [7:0] ADDR_WATCHDOG_COUNTER = 8'hff;
    localparam int POWER_DOWN_BIT = 1;
    localparam int UNLOCK_BIT = 4;
    localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
    localparam logic [7:0] COUNTER_RESET = 8'h00;
    localparam int MACHINE_DIV = 12;
    localparam int PRESCALE_BITS = 11;
    localparam int COUNTER_BITS = 8;
    localparam int PULSE_MACHINE_CYCLES = 3;
endpackage : wdtu_pkg

// file: testbench/tb_top.sv
// Watchdog unit testbench
`timescale 1ns/1ns
module tb_top;
    logic mclk = 0, arst_n = 0, watchdog_enable_strap_n = 0;
    logic sfr_wr = 0, sfr_rd = 0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic sys_reset, reset_pin_pulse, idle_mode, power_down;
    int error_cnt = 0, checks = 0, n;
    wdtu_top wdtu_top_inst (.*);
    initial forever #5 mclk = ~mclk;
    task chk(logic [7:0] g, e);
        checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value %0t %h %h", $time, g, e);
        end
    endtask : chk
    task wr(logic [7:0] a, d);
        @(posedge mclk);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge mclk);
        sfr_wr <= 1'b0;
    endtask : wr
    task rd(logic [7:0] a, e);
        @(posedge mclk);
        sfr_rd <= 1'b1;
        sfr_addr <= a;
        @(posedge mclk);
        sfr_rd <= 1'b0;
        @(negedge mclk);
        chk(sfr_rdata, e);
    endtask : rd
    // Counts cycles until sys_reset, bounded
    task wt(int lim);
        n = 0;
        while (sys_reset !== 1'b1 && n < lim)
        begin
            @(negedge mclk);
            n++;
        end
    endtask : wt
    task results;
        if (error_cnt == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    initial
    begin
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        rd(8'hff, 8'h00);
        rd(8'h87, 8'h00);
        rd(8'h10, 8'h00);
        wr(8'hff, 8'h55);
        rd(8'hff, 8'h00);
        wr(8'h87, 8'h10);
        rd(8'h87, 8'h10);
        wr(8'hff, 8'h55);
        rd(8'h87, 8'h00);
        rd(8'hff, 8'h55);
        wr(8'h87, 8'h10);
        wr(8'hff, 8'hff);
        wt(20000);
        chk(8'(n == 20000), 8'h01);
        wr(8'h87, 8'h03);
        rd(8'h87, 8'h01);
        chk({7'h00, power_down}, 8'h00);
        wr(8'h87, 8'h11);
        wr(8'hff, 8'hfe);
        wt(49300);
        chk(8'(n > 49139 && n < 49170), 8'h01);
        chk({7'h00, reset_pin_pulse}, 8'h01);
        wt(0);
        while (reset_pin_pulse === 1'b1 && n < 100)
        begin
            @(negedge mclk);
            n++;
        end
        chk(8'(n > 23 && n < 38), 8'h01);
        rd(8'hff, 8'h00);
        chk({7'h00, idle_mode}, 8'h00);
        @(posedge mclk);
        watchdog_enable_strap_n <= 1'b1;
        repeat (3) @(posedge mclk);
        wr(8'h87, 8'h02);
        rd(8'h87, 8'h02);
        chk({7'h00, power_down}, 8'h01);
        wr(8'h87, 8'h10);
        wr(8'hff, 8'hff);
        wt(25000);
        chk(8'(n == 25000), 8'h01);
        rd(8'hff, 8'hff);
        results();
    end
endmodule : tb_top

// file: testbench/wdtu_properties.sv
// Port assertions for the watchdog unit
`timescale 1ns/1ns
module wdtu_properties
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic watchdog_enable_strap_n,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic sys_reset,
    input wire logic reset_pin_pulse,
    input wire logic idle_mode,
    input wire logic power_down
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    sequence s_hold;
        reset_pin_pulse[*8];
    endsequence
    property p_pd; !watchdog_enable_strap_n[*4] |-> !power_down; endproperty
    a_pd: assert property (p_pd) else $error("pd set");
    property p_dis; watchdog_enable_strap_n[*4] |-> !sys_reset; endproperty
    a_dis: assert property (p_dis) else $error("reset off");
    property p_one; sys_reset |=> !sys_reset; endproperty
    a_one: assert property (p_one) else $error("long rst");
    property p_pair; $rose(reset_pin_pulse) |-> sys_reset; endproperty
    a_pair: assert property (p_pair) else $error("pin alone");
    property p_hold; $rose(reset_pin_pulse) |-> s_hold; endproperty
    a_hold: assert property (p_hold) else $error("pin short");
    property p_len; $rose(reset_pin_pulse) |-> ##[24:37] !reset_pin_pulse;
    endproperty
    a_len: assert property (p_len) else $error("pin long");
    property p_rz; !$past(sfr_rd) |-> sfr_rdata == 8'h00; endproperty
    a_rz: assert property (p_rz) else $error("rdata");
    property p_rpc;
        sfr_rd && sfr_addr == 8'h87 |=>
            sfr_rdata[1:0] == {power_down, idle_mode};
    endproperty
    a_rpc: assert property (p_rpc) else $error("power_control rd");
endmodule : wdtu_properties
bind wdtu_top wdtu_properties wdtu_properties_inst (.*);
